// file: dv/cwm_bus_node.sv
`timescale 1ns/100ps
module cwm_bus_node (
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic [1:0] cnt_in,
  input  wire logic [7:0] wid_in,
  input  wire logic [7:0] gap_in,
  output logic            dom_out
);
  logic [1:0] left = 2'h0;
  logic [7:0] tmr  = 8'h0;
  // leading gap, then pulse and gap in turn; bus sits recessive when idle
  always_ff @(posedge clk_in) begin
    if (go_in) begin
      left    <= cnt_in;
      tmr     <= gap_in;
      dom_out <= 1'b0;
    end else if (left != 2'h0) begin
      if (tmr > 8'h1) tmr <= tmr - 8'h1;
      else if (dom_out) begin
        dom_out <= 1'b0;
        left    <= left - 2'h1;
        tmr     <= gap_in;
      end else begin
        dom_out <= 1'b1;
        tmr     <= wid_in;
      end
    end
  end
endmodule

// file: dv/cwm_monitor_assertions.sv
`timescale 1ns/100ps
module cwm_monitor_assertions import cwm_pkg::*; #(
  parameter int TXD_P       = TXD_CYC,
  parameter int INT_PULSE_P = INT_PULSE_CYC
) (
  input wire logic        ref_clk_in,
  input wire logic        resetn_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        tx_in,
  input wire logic        driver_overtemp_in,
  input wire logic        transceiver_supply_low_in,
  input wire logic        main_regulator_uv_in,
  input wire logic        ballast_mode_in,
  input wire logic        main_regulator_on_out,
  input wire logic        mcu_reset_n_out,
  input wire logic        int_n_out,
  input wire logic        driver_enable_out,
  input wire logic        receiver_enable_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  int tx_low_cnt;
  int int_low_cnt;
  // run lengths; the tx count saturates so a long stall cannot wrap
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_low_cnt  <= 0;
      int_low_cnt <= 0;
    end else begin
      tx_low_cnt  <= tx_in ? 0 : (tx_low_cnt < TXD_P + 9 ? tx_low_cnt + 1 : tx_low_cnt);
      int_low_cnt <= int_n_out ? 0 : int_low_cnt + 1;
    end
  end
  // margins cover the two-flop synchronisers and the output register
  sequence tx_idle_s;
    (tx_in && !driver_overtemp_in && receiver_enable_out) [*8];
  endsequence
  sequence hot_s;
    driver_overtemp_in [*6];
  endsequence
  chk_stuck_off: assert property (tx_low_cnt > TXD_P + 5 |-> !driver_enable_out)
    else $error("driver on with transmit stuck dominant");
  chk_drv_back: assert property (tx_idle_s |-> driver_enable_out)
    else $error("driver not back after fault ended");
  chk_hot_off: assert property (hot_s |-> !driver_enable_out)
    else $error("driver on during overtemperature");
  chk_low_off: assert property ((ballast_mode_in && transceiver_supply_low_in) [*6]
    |-> !driver_enable_out && !receiver_enable_out) else $error("transceiver on, supply low");
  chk_uv_reset: assert property ((!ballast_mode_in && main_regulator_uv_in) [*6]
    |-> !mcu_reset_n_out) else $error("no reset on regulator undervoltage");
  chk_mcu_order: assert property ($rose(mcu_reset_n_out)
    |-> $past(main_regulator_on_out, 8))
    else $error("mcu reset released before regulator on");
  chk_int_width: assert property ($rose(int_n_out) |-> int_low_cnt == INT_PULSE_P)
    else $error("interrupt pulse width wrong");
  chk_apb_ready: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready in access cycle");
  chk_err_data: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("error response without ready or with data");
endmodule

// file: dv/cwm_monitor_tb.sv
`timescale 1ns/100ps
module cwm_monitor_tb;
  import cwm_pkg::*;
  localparam int TXD_T = 100;
  localparam int INT_T = 16;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, pen, pwr, prdy, perr, go;
  logic [7:0]  padr, wid, gap;
  logic [31:0] pwd, prd;
  logic        wdom, tx, hot, ocur, slow, uv, blst;
  logic        regon, mrst_n, int_n, drv, rxe, son;
  logic [1:0]  cnt;
  logic [2:0]  obs;
  logic [32:0] expq[$];
  int          miscompares = 0, samples_checked = 0, cyc = 0, w, g, n;
  // shortened counts keep the run brief
  cwm_monitor #(.WAKE_MIN_P(8), .WAKE_MAX_P(200), .WAKE_GAP_P(200), .WAKE_WIN_P(400),
    .TXD_P(TXD_T), .INT_PULSE_P(INT_T)) i_cwm_monitor (
    .ref_clk_in(clk), .resetn_in(rst_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .wake_dominant_in(wdom), .tx_in(tx),
    .driver_overtemp_in(hot), .driver_overcurrent_in(ocur),
    .transceiver_supply_low_in(slow), .main_regulator_uv_in(uv), .ballast_mode_in(blst),
    .main_regulator_on_out(regon), .transceiver_supply_on_out(son), .mcu_reset_n_out(mrst_n),
    .int_n_out(int_n), .driver_enable_out(drv), .receiver_enable_out(rxe));
  cwm_bus_node i_cwm_bus_node (.clk_in(clk), .go_in(go), .cnt_in(cnt), .wid_in(wid),
    .gap_in(gap), .dom_out(wdom));
  assign obs = {int_n, regon, mrst_n};
  always #4 clk = ~clk;
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one transfer: setup, then access held until ready is sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= wr;
    padr <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no fixed wait count: only the hang guard ends a stalled transfer
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic hold(input string nm, input int s, input logic v);
    int i;
    for (i = 0; i < 600 && obs[s] !== v; i++) @(posedge clk);
    chk(nm, v, obs[s]);
  endtask
  task automatic pat(input int c, input int pw, input int pg);
    @(posedge clk);
    cnt <= c[1:0];
    wid <= pw[7:0];
    gap <= pg[7:0];
    go  <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // read results are matched, oldest note first, as ready shows
  always @(posedge clk) begin
    if (psel && pen && prdy && !pwr && expq.size() > 0) begin
      chk("prdata", expq.pop_front(), {perr, prd});
    end
  end
  // hang guard, well above the planned length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    {psel, pen, pwr, hot, ocur, slow, uv, blst, cnt} = '0;
    {padr, pwd, wid, gap} = '0;
    tx = 1'b1;
    go = 1'b1;
    void'($urandom(13));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    go    <= 1'b0;
    hold("mcu_reset_n", 0, 1'b1);
    chk("transceiver_supply_on", 33'h1, son);
    rd(OFS_CTRL, 33'h0);
    rd(OFS_XCVR, 33'h0);
    rd(OFS_INTEN, {31'h0, INTEN_RST});
    rd(8'h14, 33'h1_0000_0000);
    $display("register test done");
    tx <= 1'b0;
    repeat (TXD_T + 10) @(posedge clk);
    chk("driver_enable", 33'h0, drv);
    rd(OFS_XCVR, 33'h4);
    rd(OFS_XCVR, 33'h4);
    tx <= 1'b1;
    repeat (6) @(posedge clk);
    chk("driver_enable", 33'h1, drv);
    rd(OFS_XCVR, 33'h4);
    rd(OFS_XCVR, 33'h0);
    rd(OFS_CTRL, 33'h8);
    rd(OFS_CTRL, 33'h0);
    hot  <= 1'b1;
    ocur <= 1'b1;
    repeat (8) @(posedge clk);
    ocur <= 1'b0;
    chk("driver_enable", 33'h0, drv);
    repeat (4) @(posedge clk);
    rd(OFS_XCVR, 33'hA);
    rd(OFS_XCVR, 33'h8);
    hot <= 1'b0;
    repeat (6) @(posedge clk);
    chk("driver_enable", 33'h1, drv);
    rd(OFS_XCVR, 33'h8);
    rd(OFS_XCVR, 33'h0);
    rd(OFS_CTRL, 33'h8);
    $display("driver fault test done");
    apb(1'b1, OFS_INTEN, 32'h2);
    blst <= 1'b1;
    slow <= 1'b1;
    hold("int_n", 2, 1'b0);
    repeat (3) @(posedge clk);
    chk("receiver_enable", 33'h0, rxe);
    rd(OFS_IO, 33'h3);
    slow <= 1'b0;
    repeat (4) @(posedge clk);
    rd(OFS_IO, 33'h1);
    rd(OFS_IO, 33'h0);
    blst <= 1'b0;
    $display("supply test done");
    apb(1'b1, OFS_CMD, 32'h31);
    rd(OFS_CMD, 33'h31);
    // the pattern runs in standby so that mode is exercised too
    apb(1'b1, OFS_CTRL, {29'h0, DM_STANDBY});
    rd(OFS_CTRL, 33'h1);
    for (int k = 5; k >= 0; k--) begin
      n = (k == 5) ? 2 : 3;
      w = $urandom_range(80, 8);
      g = $urandom_range(40, 8);
      if (k == 4) w = 90;
      if (k == 4) g = 120;
      if (k == 3) g = 220;
      if (k == 2) w = 210;
      if (k == 1) w = 4;
      pat(n, w, g);
      repeat (n * (w + g) + 220) @(posedge clk);
      rd(OFS_XCVR, (k == 0) ? 33'h1 : 33'h0);
    end
    rd(OFS_XCVR, 33'h1);
    apb(1'b1, OFS_XCVR, 32'h0);
    rd(OFS_XCVR, 33'h1);
    rd(OFS_XCVR, 33'h0);
    apb(1'b1, OFS_XCVR, 32'h3);
    pat(3, 20, 20);
    repeat (300) @(posedge clk);
    apb(1'b1, OFS_XCVR, 32'h0);
    rd(OFS_XCVR, 33'h0);
    $display("wake pattern test done");
    apb(1'b1, OFS_XCVR, 32'h1);
    apb(1'b1, OFS_CTRL, {29'h0, DM_STOP});
    pat(3, 20, 20);
    hold("int_n", 2, 1'b0);
    repeat (100) @(posedge clk);
    apb(1'b1, OFS_XCVR, 32'h0);
    rd(OFS_XCVR, 33'h1);
    apb(1'b1, OFS_XCVR, 32'h1);
    apb(1'b1, OFS_CTRL, {29'h0, DM_SLEEP});
    repeat (4) @(posedge clk);
    chk("main_regulator_on", 33'h0, regon);
    chk("transceiver_supply_on", 33'h0, son);
    pat(3, 20, 20);
    hold("main_regulator_on", 1, 1'b1);
    hold("mcu_reset_n", 0, 1'b1);
    $display("low power wake test done");
    uv <= 1'b1;
    repeat (8) @(posedge clk);
    chk("mcu_reset_n", 33'h0, mrst_n);
    uv <= 1'b0;
    hold("mcu_reset_n", 0, 1'b1);
    rd(OFS_IO, 33'h1);
    $display("undervoltage test done");
    end_sim();
  end
endmodule
bind cwm_monitor cwm_monitor_assertions #(.TXD_P(TXD_P), .INT_PULSE_P(INT_PULSE_P))
  i_cwm_monitor_assertions (.ref_clk_in, .resetn_in, .psel_in, .penable_in, .prdata_out,
  .pready_out, .pslverr_out, .tx_in, .driver_overtemp_in, .transceiver_supply_low_in,
  .main_regulator_uv_in, .ballast_mode_in, .main_regulator_on_out, .mcu_reset_n_out,
  .int_n_out, .driver_enable_out, .receiver_enable_out);

// file: hw/cwm_monitor.sv
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
module cwm_monitor import cwm_pkg::*; #(
  parameter int WAKE_MIN_P   = WAKE_MIN_CYC,
  parameter int WAKE_MAX_P   = WAKE_MAX_CYC,
  parameter int WAKE_GAP_P   = WAKE_GAP_CYC,
  parameter int WAKE_WIN_P   = WAKE_WIN_CYC,
  parameter int TXD_P        = TXD_CYC,
  parameter int INT_PULSE_P  = INT_PULSE_CYC,
  parameter int RESET_HOLD_P = RESET_HOLD_CYC
) (
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        wake_dominant_in,
  input  wire logic        tx_in,
  input  wire logic        driver_overtemp_in,
  input  wire logic        driver_overcurrent_in,
  input  wire logic        transceiver_supply_low_in,
  input  wire logic        main_regulator_uv_in,
  input  wire logic        ballast_mode_in,
  output logic             main_regulator_on_out,
  output logic             transceiver_supply_on_out,
  output logic             mcu_reset_n_out,
  output logic             int_n_out,
  output logic             driver_enable_out,
  output logic             receiver_enable_out
);
  // elaboration checks on the timing parameters
  if (WAKE_MIN_P < 1 || WAKE_MIN_P >= WAKE_MAX_P || WAKE_MAX_P > WAKE_WIN_P) begin : g_bad_wake
    $error("wake timing parameters inconsistent");
  end
  if (WAKE_WIN_P >= 2**CNT_W || TXD_P >= 2**CNT_W || WAKE_GAP_P >= 2**CNT_W) begin : g_bad_w
    $error("timing parameter exceeds counter width");
  end
  if (INT_PULSE_P < 1 || INT_PULSE_P > 255
      || RESET_HOLD_P < 1 || RESET_HOLD_P > 255) begin : g_bad_p
    $error("pulse or reset hold parameter out of range");
  end

  localparam logic [CNT_W-1:0] MIN_C = CNT_W'(WAKE_MIN_P);
  localparam logic [CNT_W-1:0] MAX_C = CNT_W'(WAKE_MAX_P);
  localparam logic [CNT_W-1:0] GAP_C = CNT_W'(WAKE_GAP_P);
  localparam logic [CNT_W-1:0] WIN_C = CNT_W'(WAKE_WIN_P);
  localparam logic [CNT_W-1:0] TXD_C = CNT_W'(TXD_P);
  localparam logic [7:0]       INT_C = 8'(INT_PULSE_P);
  localparam logic [7:0]       RST_C = 8'(RESET_HOLD_P);
  localparam logic [1:0]       NPUL  = 2'(WAKE_PULSES);

  // two-flop synchronisers; only the second stage is read by logic
  cwm_pins_t pin_raw;
  cwm_pins_t sync_a;
  cwm_pins_t pin;
  assign pin_raw = '{ballast: ballast_mode_in, uv: main_regulator_uv_in,
                     supply_low: transceiver_supply_low_in,
                     overcurrent: driver_overcurrent_in, overtemp: driver_overtemp_in,
                     tx: tx_in, wake_dom: wake_dominant_in};
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_a <= '{ballast: 1'b0, uv: 1'b0, supply_low: 1'b0, overcurrent: 1'b0,
                  overtemp: 1'b0, tx: 1'b1, wake_dom: 1'b0};
      pin    <= '{ballast: 1'b0, uv: 1'b0, supply_low: 1'b0, overcurrent: 1'b0,
                  overtemp: 1'b0, tx: 1'b1, wake_dom: 1'b0};
    end else begin
      sync_a <= pin_raw;
      pin    <= sync_a;
    end
  end

  cwm_dev_mode_t  dev_mode;
  cwm_xcvr_mode_t xcvr_mode;
  cwm_wake_st_t   wake_st;
  cwm_flags_t     flags;
  logic             fail_flag;
  logic             slow_flag;
  logic [1:0]       inten;
  logic             tx_stuck;
  logic [CNT_W-1:0] txd_cnt;
  logic [CNT_W-1:0] width_cnt;
  logic [CNT_W-1:0] gap_cnt;
  logic [CNT_W-1:0] win_cnt;
  logic [1:0]       pul_cnt;
  logic             wake_evt;
  logic [7:0]       int_cnt;
  logic [7:0]       rst_cnt;
  logic [7:0]       cmd_resp;
  logic             ot_d;
  logic             oc_d;
  logic             stuck_d;
  logic             slow_d;

  // live supply-low depends on how the transceiver supply is fed
  logic slow_live;
  assign slow_live = pin.ballast ? pin.supply_low : pin.uv;

  // apb phases: reads snapshot and clear at setup, writes land at completion
  logic setup;
  logic done;
  assign setup = psel_in && !penable_in;
  assign done  = psel_in && penable_in && pready_out;

  // register access, either direct or through the command byte
  logic       cmd_sel;
  logic       acc_map;
  logic [2:0] acc_idx;
  logic       acc_rw;
  logic [3:0] acc_data;
  always_comb begin
    cmd_sel  = paddr_in == OFS_CMD;
    acc_map  = 1'b1;
    acc_idx  = IDX_CTRL;
    acc_rw   = pwrite_in;
    acc_data = pwdata_in[3:0];
    case (paddr_in)
      OFS_CTRL:  acc_idx = IDX_CTRL;
      OFS_XCVR:  acc_idx = IDX_XCVR;
      OFS_IO:    acc_idx = IDX_IO;
      OFS_INTEN: acc_idx = IDX_INTEN;
      OFS_CMD: begin
        acc_idx = pwdata_in[CMD_ADR_MSB:CMD_ADR_LSB];
        acc_rw  = pwdata_in[CMD_RW_BIT];
      end
      default:   acc_map = 1'b0;
    endcase
  end

  // a command byte is only acted on when written
  logic do_rd;
  logic do_wr;
  assign do_rd = acc_map && !acc_rw && (cmd_sel ? (pwrite_in && done) : setup);
  assign do_wr = acc_map && acc_rw && pwrite_in && done;

  logic [3:0] rd_val;
  always_comb begin
    case (acc_idx)
      IDX_CTRL:  rd_val = {fail_flag, dev_mode};
      IDX_XCVR:  rd_val = flags;
      IDX_IO:    rd_val = {2'b00, slow_live, slow_flag};
      IDX_INTEN: rd_val = {2'b00, inten};
      default:   rd_val = 4'h0;
    endcase
  end

  logic rd_ctrl;
  logic rd_xcvr;
  logic rd_io;
  assign rd_ctrl = do_rd && acc_idx == IDX_CTRL;
  assign rd_xcvr = do_rd && acc_idx == IDX_XCVR;
  assign rd_io   = do_rd && acc_idx == IDX_IO;

  // apb answer: one access cycle, no waits
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup && !acc_map;
      if (setup) begin
        prdata_out <= 32'h0;
        if (!pwrite_in && cmd_sel) begin
          prdata_out <= {24'h0, cmd_resp};
        end else if (!pwrite_in && acc_map) begin
          prdata_out <= {28'h0, rd_val};
        end
      end
    end
  end

  // command byte echo: address, direction and the nibble written or read back
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmd_resp <= 8'h0;
    end else if (cmd_sel && pwrite_in && done && acc_map) begin
      cmd_resp <= {acc_idx, acc_rw, acc_rw ? acc_data : rd_val};
    end
  end

  // transceiver mode and interrupt enables
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      xcvr_mode <= XM_NORMAL;
      inten     <= INTEN_RST;
    end else if (do_wr) begin
      if (acc_idx == IDX_XCVR) begin
        case (acc_data[1:0])
          XM_NORMAL:       xcvr_mode <= XM_NORMAL;
          XM_SLEEP_WAKE:   xcvr_mode <= XM_SLEEP_WAKE;
          XM_SLEEP_NOWAKE: xcvr_mode <= XM_SLEEP_NOWAKE;
          default:         xcvr_mode <= xcvr_mode;
        endcase
      end
      if (acc_idx == IDX_INTEN) begin
        inten <= acc_data[1:0];
      end
    end
  end

  // pattern detector runs only while asleep with wake armed
  logic armed;
  logic dom;
  assign armed = xcvr_mode == XM_SLEEP_WAKE;
  assign dom   = pin.wake_dom;
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wake_st   <= WK_IDLE;
      width_cnt <= '0;
      gap_cnt   <= '0;
      win_cnt   <= '0;
      pul_cnt   <= 2'h0;
      wake_evt  <= 1'b0;
    end else begin
      wake_evt <= 1'b0;
      if (wake_st != WK_IDLE && win_cnt != WIN_C) begin
        win_cnt <= win_cnt + 1'b1;
      end
      if (!armed) begin
        wake_st   <= WK_IDLE;
        pul_cnt   <= 2'h0;
        win_cnt   <= '0;
        width_cnt <= '0;
        gap_cnt   <= '0;
      end else begin
        case (wake_st)
          WK_IDLE: begin
            win_cnt <= '0;
            pul_cnt <= 2'h0;
            if (dom) begin
              wake_st   <= WK_PULSE;
              width_cnt <= CNT_W'(1);
            end
          end
          WK_PULSE: begin
            if (win_cnt >= WIN_C || width_cnt >= MAX_C) begin
              wake_st <= WK_BAD;
              pul_cnt <= 2'h0;
            end else if (dom) begin
              width_cnt <= width_cnt + 1'b1;
            end else if (width_cnt < MIN_C) begin
              wake_st <= WK_IDLE;
              pul_cnt <= 2'h0;
            end else if (pul_cnt + 2'h1 == NPUL) begin
              wake_st  <= WK_IDLE;
              pul_cnt  <= 2'h0;
              wake_evt <= 1'b1;
            end else begin
              wake_st <= WK_GAP;
              pul_cnt <= pul_cnt + 2'h1;
              gap_cnt <= '0;
            end
          end
          WK_GAP: begin
            if (win_cnt >= WIN_C || gap_cnt >= GAP_C) begin
              wake_st <= dom ? WK_BAD : WK_IDLE;
              pul_cnt <= 2'h0;
            end else if (dom) begin
              wake_st   <= WK_PULSE;
              width_cnt <= CNT_W'(1);
            end else begin
              gap_cnt <= gap_cnt + 1'b1;
            end
          end
          WK_BAD: begin
            // overlong pulse must end before a new one can start
            pul_cnt <= 2'h0;
            if (!dom) begin
              wake_st <= WK_IDLE;
            end
          end
          default: wake_st <= WK_IDLE;
        endcase
      end
    end
  end

  // stuck-dominant timer on the transmit input
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      txd_cnt  <= '0;
      tx_stuck <= 1'b0;
    end else if (pin.tx) begin
      txd_cnt  <= '0;
      tx_stuck <= 1'b0;
    end else if (txd_cnt >= TXD_C) begin
      tx_stuck <= 1'b1;
    end else begin
      txd_cnt <= txd_cnt + 1'b1;
    end
  end

  // fault edges for the general flag and interrupt
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ot_d    <= 1'b0;
      oc_d    <= 1'b0;
      stuck_d <= 1'b0;
      slow_d  <= 1'b0;
    end else begin
      ot_d    <= pin.overtemp;
      oc_d    <= pin.overcurrent;
      stuck_d <= tx_stuck;
      slow_d  <= slow_live;
    end
  end
  logic fail_evt;
  logic slow_evt;
  assign fail_evt = (tx_stuck && !stuck_d) || (pin.overtemp && !ot_d)
                  || (pin.overcurrent && !oc_d);
  assign slow_evt = slow_live && !slow_d;

  // latched flags: a set in the clearing read cycle wins
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flags     <= '0;
      fail_flag <= 1'b0;
      slow_flag <= 1'b0;
    end else begin
      if (wake_evt) begin
        flags.bus_wake <= 1'b1;
      end else if (rd_xcvr && xcvr_mode == XM_NORMAL) begin
        flags.bus_wake <= 1'b0;
      end
      if (tx_stuck) begin
        flags.tx_stuck <= 1'b1;
      end else if (rd_xcvr) begin
        flags.tx_stuck <= 1'b0;
      end
      if (pin.overtemp) begin
        flags.overtemp <= 1'b1;
      end else if (rd_xcvr) begin
        flags.overtemp <= 1'b0;
      end
      if (pin.overcurrent) begin
        flags.overcurrent <= 1'b1;
      end else if (rd_xcvr) begin
        flags.overcurrent <= 1'b0;
      end
      if (fail_evt) begin
        fail_flag <= 1'b1;
      end else if (rd_ctrl && !tx_stuck && !pin.overtemp && !pin.overcurrent) begin
        fail_flag <= 1'b0;
      end
      if (slow_live) begin
        slow_flag <= 1'b1;
      end else if (rd_io) begin
        slow_flag <= 1'b0;
      end
    end
  end

  // device mode; undervoltage beats wake-up beats software
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dev_mode <= DM_RESET;
      rst_cnt  <= 8'h0;
    end else if (!pin.ballast && pin.uv) begin
      dev_mode <= DM_RESET;
      rst_cnt  <= 8'h0;
    end else if (wake_evt && dev_mode == DM_SLEEP) begin
      dev_mode <= DM_RESET;
      rst_cnt  <= 8'h0;
    end else if (wake_evt && dev_mode == DM_STOP) begin
      dev_mode <= DM_NORMAL;
    end else if (dev_mode == DM_RESET) begin
      // mcu held in reset for a fixed time after the regulator comes up
      if (rst_cnt >= RST_C) begin
        dev_mode <= DM_NORMAL;
      end else begin
        rst_cnt <= rst_cnt + 8'h1;
      end
    end else if (do_wr && acc_idx == IDX_CTRL) begin
      case (acc_data[2:0])
        DM_NORMAL:  dev_mode <= DM_NORMAL;
        DM_STANDBY: dev_mode <= DM_STANDBY;
        DM_STOP:    dev_mode <= DM_STOP;
        DM_SLEEP:   dev_mode <= DM_SLEEP;
        default:    dev_mode <= dev_mode;
      endcase
    end
  end

  // interrupt pulse: stop-mode wake always, faults when enabled
  logic int_trig;
  assign int_trig = (wake_evt && dev_mode == DM_STOP)
                  || (fail_evt && inten[INTEN_FAIL_BIT])
                  || (slow_evt && inten[INTEN_SLOW_BIT]);
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      int_cnt   <= 8'h0;
      int_n_out <= 1'b1;
    end else begin
      if (int_trig) begin
        int_cnt <= INT_C;
      end else if (int_cnt != 8'h0) begin
        int_cnt <= int_cnt - 8'h1;
      end
      int_n_out <= !(int_trig || int_cnt > 8'h1);
    end
  end

  // supply and driver controls, all registered
  logic sup_on;
  assign sup_on = dev_mode == DM_NORMAL || (dev_mode == DM_STANDBY && !pin.ballast);
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      main_regulator_on_out     <= 1'b1;
      transceiver_supply_on_out <= 1'b0;
      mcu_reset_n_out           <= 1'b0;
      driver_enable_out         <= 1'b0;
      receiver_enable_out       <= 1'b0;
    end else begin
      main_regulator_on_out     <= dev_mode != DM_SLEEP;
      transceiver_supply_on_out <= sup_on;
      mcu_reset_n_out           <= dev_mode != DM_RESET;
      driver_enable_out         <= xcvr_mode == XM_NORMAL && sup_on && !slow_live
                                   && !tx_stuck && !pin.overtemp;
      receiver_enable_out       <= xcvr_mode == XM_NORMAL && sup_on && !slow_live;
    end
  end
endmodule

// file: shared/cwm_pkg.sv
package cwm_pkg;
  localparam int CLK_MHZ      = 125;
  localparam int CNT_W        = 17;
  localparam int WAKE_PULSES  = 3;
  localparam int WAKE_MIN_NS  = 500;
  localparam int WAKE_MIN_CYC = (WAKE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_MAX_US  = 500;
  localparam int WAKE_MAX_CYC = WAKE_MAX_US * CLK_MHZ;
  localparam int WAKE_GAP_US  = 500;
  localparam int WAKE_GAP_CYC = WAKE_GAP_US * CLK_MHZ;
  localparam int WAKE_WIN_MS  = 1;
  localparam int WAKE_WIN_CYC = WAKE_WIN_MS * 1000 * CLK_MHZ;
  localparam int TXD_US       = 360;
  localparam int TXD_CYC      = TXD_US * CLK_MHZ;
  localparam int INT_PULSE_CYC  = 16;
  localparam int RESET_HOLD_CYC = 32;

  // apb byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_XCVR  = 8'h04;
  localparam logic [7:0] OFS_IO    = 8'h08;
  localparam logic [7:0] OFS_INTEN = 8'h0C;
  localparam logic [7:0] OFS_CMD   = 8'h10;
  // command byte register indices and fields
  localparam logic [2:0] IDX_CTRL  = 3'h0;
  localparam logic [2:0] IDX_XCVR  = 3'h1;
  localparam logic [2:0] IDX_IO    = 3'h2;
  localparam logic [2:0] IDX_INTEN = 3'h3;
  localparam int CMD_ADR_MSB = 7;
  localparam int CMD_ADR_LSB = 5;
  localparam int CMD_RW_BIT  = 4;
  localparam int CTRL_FAIL_BIT  = 3;
  localparam int IO_SLOW_BIT    = 0;
  localparam int IO_LIVE_BIT    = 1;
  localparam int INTEN_FAIL_BIT = 0;
  localparam int INTEN_SLOW_BIT = 1;
  localparam logic [1:0] INTEN_RST = 2'h0;

  typedef enum logic [2:0] {
    DM_NORMAL  = 3'b000,
    DM_STANDBY = 3'b001,
    DM_STOP    = 3'b011,
    DM_SLEEP   = 3'b010,
    DM_RESET   = 3'b110
  } cwm_dev_mode_t;

  typedef enum logic [1:0] {
    XM_NORMAL       = 2'b00,
    XM_SLEEP_WAKE   = 2'b01,
    XM_SLEEP_NOWAKE = 2'b11
  } cwm_xcvr_mode_t;

  typedef enum logic [1:0] {
    WK_IDLE  = 2'b00,
    WK_PULSE = 2'b01,
    WK_GAP   = 2'b11,
    WK_BAD   = 2'b10
  } cwm_wake_st_t;

  // transceiver register readout, bit 2 is the transmit fault
  typedef struct packed {
    logic overtemp;
    logic tx_stuck;
    logic overcurrent;
    logic bus_wake;
  } cwm_flags_t;

  // synchronised pins
  typedef struct packed {
    logic ballast;
    logic uv;
    logic supply_low;
    logic overcurrent;
    logic overtemp;
    logic tx;
    logic wake_dom;
  } cwm_pins_t;
endpackage
